// >>> common/adc_cycle_pkg.sv
// Package: constants, states and carriers for the converter cycle control
package adc_cycle_pkg;
   localparam int RESULT_W = 16;
   localparam int CLK_HZ = 20000000;
   localparam real CONV_TIME_MS = 16.6;
   localparam real POR_TIME_MS = 0.5;
   localparam int CONV_CYCLES = int'(CONV_TIME_MS * CLK_HZ / 1000.0);
   localparam int POR_CYCLES = int'(POR_TIME_MS * CLK_HZ / 1000.0);
   localparam int CNT_W = 24;
   localparam int BIT_CNT_W = 5;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_MAX = 16'hFFFF;
   localparam logic [15:0] CODE_MIN = 16'h0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   typedef enum logic [2:0] {
      ST_CONVERT = 3'b001,
      ST_SLEEP = 3'b010,
      ST_OUTPUT = 3'b100
   } cycle_state_e;

   // Serial port pins after the sampling flops
   typedef struct packed {
      logic csn;
      logic sck;
   } link_in_s;

   // Serial data output pin as value and enable
   typedef struct packed {
      logic sdo;
      logic sdoOen;
   } link_out_s;

   // Converter core handshake
   typedef struct packed {
      logic convBusy;
      logic lowPower;
      logic porActive;
   } core_status_s;
endpackage

// >>> design/link_sampler.sv
// Two-flop sampler and edge finder for the serial port inputs
`timescale 1ns/100ps
module link_sampler (
   input wire logic clk,
   input wire logic resetn,
   input wire logic csn,
   input wire logic sck,
   output adc_cycle_pkg::link_in_s level,
   output logic sckFall,
   output logic csnRise
);
   typedef struct packed {
      adc_cycle_pkg::link_in_s meta;
      adc_cycle_pkg::link_in_s sync;
      adc_cycle_pkg::link_in_s prev;
   } sampler_s;

   sampler_s r;
   sampler_s next_r;

   always_comb begin
      next_r = r;
      next_r.meta = '{csn: csn, sck: sck};
      next_r.sync = r.meta;
      next_r.prev = r.sync;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '{meta: '{csn: 1'b1, sck: 1'b0}, sync: '{csn: 1'b1, sck: 1'b0},
                prev: '{csn: 1'b1, sck: 1'b0}};
      end else begin
         r <= next_r;
      end
   end

   assign level = r.sync;
   assign sckFall = r.prev.sck & ~r.sync.sck;
   assign csnRise = ~r.prev.csn & r.sync.csn;
endmodule // link_sampler

// >>> design/adc_cycle_serial_readout.sv
// Converter cycle sequencer with serial result readout
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module adc_cycle_serial_readout #(
   parameter int CONV_CYCLES = adc_cycle_pkg::CONV_CYCLES,
   parameter int POR_CYCLES = adc_cycle_pkg::POR_CYCLES,
   parameter int RESULT_W = adc_cycle_pkg::RESULT_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic supplyLow,
   input wire logic signed [RESULT_W+1:0] differentialInput,
   input wire logic signed [RESULT_W+1:0] referenceLevel,
   input wire logic csn,
   input wire logic sck,
   output logic sdo,
   output logic sdoOen,
   output logic convBusy,
   output logic lowPower,
   output logic porActive,
   output logic [2:0] cycleState
);
   ///////////////////////////////////////////////////////////////////////////
   // Code computation from the sampled input
   function automatic logic [15:0] scale_code(
      input logic signed [RESULT_W+1:0] differential_input,
      input logic signed [RESULT_W+1:0] vref
   );
      logic signed [63:0] prod;
      logic signed [63:0] code;
      prod = 64'(differential_input) * 64'sd32768;
      code = 64'sd0;
      if (vref <= 0) begin
         code = 64'(adc_cycle_pkg::CODE_MID);
      end else if (differential_input >= vref) begin
         code = 64'(adc_cycle_pkg::CODE_MAX);
      end else if (differential_input <= -vref) begin
         code = 64'(adc_cycle_pkg::CODE_MIN);
      end else begin
         code = prod / 64'(vref) + $signed(64'(adc_cycle_pkg::CODE_MID));
         if (prod < 0 && (prod % 64'(vref)) != 0) begin
            code = code - 64'sd1;
         end
      end
      return code[15:0];
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // Input sampling
   adc_cycle_pkg::link_in_s link;
   logic sckFall;
   logic csnRise;

   link_sampler sampler (
      .clk(clk),
      .resetn(resetn),
      .csn(csn),
      .sck(sck),
      .level(link),
      .sckFall(sckFall),
      .csnRise(csnRise)
   );

   logic [1:0] supplySync;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         supplySync <= 2'b00;
      end else begin
         supplySync <= {supplySync[0], supplyLow};
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      adc_cycle_pkg::cycle_state_e state;
      logic [adc_cycle_pkg::CNT_W-1:0] timer;
      logic por;
      logic [15:0] result;
      logic [15:0] shift;
      logic [adc_cycle_pkg::BIT_CNT_W-1:0] bitCount;
      adc_cycle_pkg::link_out_s out;
      logic lowPower;
   } core_s;

   localparam logic [adc_cycle_pkg::CNT_W-1:0] CONV_LAST =
      adc_cycle_pkg::CNT_W'(CONV_CYCLES - 1);
   localparam logic [adc_cycle_pkg::CNT_W-1:0] POR_LAST =
      adc_cycle_pkg::CNT_W'(POR_CYCLES - 1);
   localparam logic [adc_cycle_pkg::BIT_CNT_W-1:0] LAST_FALL =
      adc_cycle_pkg::BIT_CNT_W'(RESULT_W - 1);

   // Cleared state shared by reset and supply loss
   localparam core_s CORE_RESET = '{
      state: adc_cycle_pkg::ST_CONVERT,
      timer: '0,
      por: 1'b1,
      result: adc_cycle_pkg::RESULT_RESET,
      shift: '0,
      bitCount: '0,
      out: '{sdo: 1'b0, sdoOen: 1'b1},
      lowPower: 1'b0
   };

   core_s r;
   core_s next_r;
   logic porTrigger;

   assign porTrigger = supplySync[1];

   ///////////////////////////////////////////////////////////////////////////
   // Next-state helpers
   function automatic core_s por_step(input core_s cur);
      core_s nxt;
      nxt = cur;
      nxt.timer = cur.timer + 1'b1;
      if (cur.timer == POR_LAST) begin
         nxt.por = 1'b0;
         nxt.timer = '0;
      end
      return nxt;
   endfunction

   function automatic core_s convert_step(
      input core_s cur,
      input logic [15:0] code
   );
      core_s nxt;
      nxt = cur;
      // Serial inputs ignored here
      nxt.timer = cur.timer + 1'b1;
      if (cur.timer == CONV_LAST) begin
         nxt.result = code;
         nxt.timer = '0;
         nxt.state = adc_cycle_pkg::ST_SLEEP;
      end
      return nxt;
   endfunction

   function automatic core_s sleep_step(
      input core_s cur,
      input adc_cycle_pkg::link_in_s lnk
   );
      core_s nxt;
      nxt = cur;
      // Result register left untouched
      nxt.lowPower = lnk.csn;
      if (!lnk.csn && !lnk.sck) begin
         nxt.shift = cur.result;
         nxt.bitCount = '0;
         nxt.lowPower = 1'b0;
         nxt.state = adc_cycle_pkg::ST_OUTPUT;
      end
      return nxt;
   endfunction

   function automatic core_s output_step(
      input core_s cur,
      input logic rise,
      input logic fall
   );
      core_s nxt;
      nxt = cur;
      if (rise) begin
         nxt.shift = '0;
         nxt.state = adc_cycle_pkg::ST_CONVERT;
      end else if (fall) begin
         nxt.shift = {cur.shift[14:0], 1'b0};
         nxt.bitCount = cur.bitCount + 1'b1;
         if (cur.bitCount == LAST_FALL) begin
            nxt.state = adc_cycle_pkg::ST_CONVERT;
         end
      end
      return nxt;
   endfunction

   function automatic adc_cycle_pkg::link_out_s drive_out(
      input core_s nxt,
      input adc_cycle_pkg::link_in_s lnk
   );
      adc_cycle_pkg::link_out_s o;
      o.sdoOen = lnk.csn;
      case (nxt.state)
         adc_cycle_pkg::ST_OUTPUT: o.sdo = nxt.shift[15];
         adc_cycle_pkg::ST_CONVERT: o.sdo = 1'b1;
         default: o.sdo = 1'b0;
      endcase
      return o;
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      next_r = r;
      if (porTrigger) begin
         next_r = CORE_RESET;
      end else if (r.por) begin
         next_r = por_step(r);
      end else begin
         case (r.state)
            adc_cycle_pkg::ST_CONVERT: begin
               next_r = convert_step(r, scale_code(differentialInput, referenceLevel));
            end
            adc_cycle_pkg::ST_SLEEP: begin
               next_r = sleep_step(r, link);
            end
            adc_cycle_pkg::ST_OUTPUT: begin
               next_r = output_step(r, csnRise, sckFall);
            end
            default: begin
               next_r.state = adc_cycle_pkg::ST_CONVERT;
            end
         endcase
         next_r.out = drive_out(next_r, link);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= CORE_RESET;
      end else begin
         r <= next_r;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Outputs
   assign sdo = r.out.sdo;
   assign sdoOen = r.out.sdoOen;
   assign convBusy = (r.state == adc_cycle_pkg::ST_CONVERT);
   assign lowPower = r.lowPower;
   assign porActive = r.por;
   assign cycleState = r.state;
endmodule // adc_cycle_serial_readout

// >>> tb/adc_cycle_chk.sv
// Checker of the converter cycle and its serial output
`timescale 1ns/100ps
module adc_cycle_chk #(
   parameter int CONV_CYCLES = 200,
   parameter int POR_CYCLES = 20
) (
   input logic clk,
   input logic resetn,
   input logic csn,
   input logic sdo,
   input logic sdoOen,
   input logic lowPower,
   input logic porActive,
   input logic [2:0] cycleState
);
   logic [23:0] convCnt;
   always_ff @(posedge clk) begin
      convCnt <= (cycleState[0] && !porActive) ? convCnt + 24'h1 : 24'h0;
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_sleep_entry: assert property ($rose(cycleState[1]) |-> $past(cycleState[0]))
      else $error("sleep entry");
   a_output_entry: assert property ($rose(cycleState[2]) |->
      $past(cycleState[1]) && !$past(csn, 3)) else $error("output entry");
   a_convert_time: assert property ($fell(cycleState[0]) |->
      convCnt >= CONV_CYCLES - 2 && convCnt <= CONV_CYCLES + 3) else $error("convert time");
   a_por_hold: assert property ($fell(porActive) |->
      cycleState == 3'h1 && $past(porActive, POR_CYCLES)) else $error("por hold");
   a_reset_clear: assert property ($rose(resetn) |->
      porActive && cycleState == 3'h1 && sdoOen) else $error("reset state");
   a_select_off: assert property (csn [*5] |-> sdoOen) else $error("sdo enabled");
   a_busy_status: assert property (cycleState[0] && $past(cycleState[0]) && !sdoOen |-> sdo)
      else $error("busy status");
   a_sleep_power: assert property (csn [*5] ##0 cycleState[1] && $past(cycleState[1], 2)
      |-> lowPower) else $error("low power");
   c_readout: cover property ($fell(cycleState[2]));
   c_por_done: cover property ($fell(porActive));
   c_low_power: cover property ($rose(lowPower));
endmodule // adc_cycle_chk
bind adc_cycle_serial_readout adc_cycle_chk #(.CONV_CYCLES(CONV_CYCLES), .POR_CYCLES(POR_CYCLES))
   chk (.clk, .resetn, .csn, .sdo, .sdoOen, .lowPower, .porActive, .cycleState);

// >>> tb/spi_host_model.sv
// Host model: serial master reading results and polling status
`timescale 1ns/100ps
module spi_host_model (
   input logic clk,
   input logic sdi,
   output logic csn,
   output logic sck
);
   initial begin
      csn = 1'b1;
      sck = 1'b0;
   end
   task xfer(input int n, output logic [15:0] got);
      got = 16'h0;
      @(posedge clk);
      #2;
      csn = 1'b0;
      #300;
      for (int i = 0; i < n; i++) begin
         sck = 1'b1;
         if (i < 16) got = {got[14:0], sdi};
         #200;
         sck = 1'b0;
         #200;
      end
      csn = 1'b1;
      #200;
   endtask
   task peek(output logic v);
      @(posedge clk);
      #2;
      sck = 1'b1;
      #300;
      csn = 1'b0;
      #400;
      v = sdi;
      csn = 1'b1;
      #300;
      sck = 1'b0;
      #200;
   endtask
endmodule // spi_host_model

// >>> tb/adc_cycle_serial_readout_tb.sv
// Testbench of the converter cycle sequencer with serial readout
`timescale 1ns/100ps
module adc_cycle_serial_readout_tb;
   logic clk, resetn, supplyLow, csn, sck, sdo, sdoOen, lowPower, porActive, tgl, v, convBusy;
   logic [2:0] cycleState;
   logic signed [17:0] differential_input, vref;
   logic [15:0] got;
   int bad_count, compares, e, n, p;
   int q[$];
   adc_cycle_serial_readout #(.CONV_CYCLES(200), .POR_CYCLES(20)) DUT (.clk, .resetn,
      .supplyLow, .differentialInput(differential_input), .referenceLevel(vref), .csn, .sck, .sdo,
      .sdoOen, .convBusy, .lowPower, .porActive, .cycleState);
   spi_host_model HOST (.clk, .sdi(sdoOen ? tgl : sdo), .csn, .sck);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) tgl <= ~tgl;
   initial begin
      #1000000;
      bad_count++;
      end_of_test();
   end
   task chk(input logic [15:0] s, input logic [15:0] x, input string w);
      compares++;
      if (s !== x) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", w, x, s);
      end
   endtask
   task end_of_test;
      if (bad_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task waitState(input logic [2:0] s);
      for (int k = 0; k < 2000 && cycleState !== s; k++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      #2;
      chk(16'(cycleState), 16'(s), "state");
      chk(16'(convBusy), 16'(s == 3'h1), "busy");
   endtask
   task newin(input int i);
      int r;
      int x;
      r = 1000 + int'($urandom % 8000);
      x = int'($urandom % (2 * r + 21)) - r - 10;
      x = (i == 1) ? r : (i == 2) ? -r : (i == 3) ? 0 : (i == 4) ? -1 : x;
      p = 32768 * x;
      @(posedge clk);
      #2;
      vref = 18'(r);
      differential_input = 18'(x);
      q.push_back(x >= r ? 65535 : x <= -r ? 0 : (p - (p % r + r) % r) / r + 32768);
   endtask
   initial begin
      resetn = 1'b0;
      supplyLow = 1'b0;
      tgl = 1'b0;
      differential_input = 18'h0;
      vref = 18'h1;
      void'($urandom(32'hED821945));
      newin(0);
      repeat (20) @(posedge clk);
      #2;
      resetn = 1'b1;
      for (int i = 1; i < 12; i++) begin
         waitState(3'h2);
         chk(16'(lowPower), 16'h1, "low power");
         HOST.peek(v);
         chk(16'(v), 16'h0, "status");
         waitState(3'h2);
         n = (i == 3) ? 1 : (i == 5) ? 17 : 16;
         HOST.xfer(n, got);
         e = q.pop_front();
         chk(n == 1 ? 16'(got[0]) : got, n == 1 ? 16'(e[15]) : e[15:0], "result");
         waitState(3'h1);
         HOST.peek(v);
         chk(16'(v), 16'h1, "status");
         if (i == 7) begin
            @(posedge clk);
            #2;
            supplyLow = 1'b1;
            repeat (6) @(posedge clk);
            #2;
            chk(16'(porActive), 16'h1, "por");
            supplyLow = 1'b0;
         end
         newin(i);
      end
      end_of_test();
   end
endmodule // adc_cycle_serial_readout_tb
